// File: bench/asc_ana_model.sv
// partner: converter pipeline that returns one word per sampled channel
`timescale 1ns/1ps
module asc_ana_model (
  // clock
  input wire logic pclk,
  // sequencer side
  input wire asc_pkg::asc_ana_out_s ana_out,
  output asc_pkg::asc_ana_in_s ana_in
);
  logic sh_p = 1'b0;
  logic [4:0] fall_sr = 5'h00;
  logic [7:0] junk = 8'h00;
  logic [3:0] ca = 4'h0;
  logic [3:0] cb = 4'h0;
  // the words are valid for one cycle only; the rest of the time they churn
  always @(posedge pclk) begin
    sh_p <= ana_out.sh;
    junk <= junk + 8'h01;
    fall_sr <= {fall_sr[3:0], sh_p & ~ana_out.sh};
    if (sh_p && !ana_out.sh) begin
      ca <= ana_out.chan_a;
      cb <= ana_out.chan_b;
    end
  end
  assign ana_in.data_a = fall_sr[2] ? {8'hC3, ca} : {junk, ~ca};
  assign ana_in.data_b = fall_sr[3] ? {8'h3C, cb} : {~junk, ~cb};
endmodule // asc_ana_model

// File: bench/tb.sv
// testbench of the converter sequencer
`timescale 1ns/1ps
`include "asc_map.svh"
module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, ext_pin, sh_p, irq_p;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [1:0] ev_trig;
  asc_pkg::asc_ana_out_s ana_out;
  asc_pkg::asc_ana_in_s ana_in;
  int fails, n_compared, cyc, t_irq;
  int rise_q[$];
  int fall_q[$];
  asc_ctrl u_asc_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .event_manager_triggers(ev_trig),
    .external_start_conversion(ext_pin), .ana_out(ana_out), .ana_in(ana_in), .irq(irq));
  asc_ana_model u_asc_ana_model (.pclk(pclk), .ana_out(ana_out), .ana_in(ana_in));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // edge stamps of pulse rise, pulse fall and first interrupt rise
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    sh_p <= ana_out.sh;
    irq_p <= irq;
    if (ana_out.sh && !sh_p) rise_q.push_back(cyc);
    if (!ana_out.sh && sh_p) fall_q.push_back(cyc);
    if (irq && !irq_p && t_irq < 0) t_irq = cyc;
  end
  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic hang(input int n);
    if (n >= 400) begin
      fails++;
      finish_test();
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 400);
    hang(n);
    q = w ? {31'h0, pslverr} : prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic trig(input int src);
    if (src == 1) apb(1'b1, `ASC_OFF_SWTRIG, 32'h1);
    @(posedge pclk);
    if (src == 0) ev_trig <= 2'b01;
    if (src == 3) ev_trig <= 2'b10;
    if (src == 2) ext_pin <= 1'b1;
    @(posedge pclk);
    ev_trig <= 2'b00;
  endtask
  task automatic t_power();
    apb(1'b1, `ASC_OFF_PWR, 32'h60);
    repeat (20) @(posedge pclk); // settle waits shortened: the block does not time them
    apb(1'b1, `ASC_OFF_PWR, 32'hE0);
    @(posedge pclk);
    chk({ana_out.band_gap_power_bit, ana_out.reference_power_bit,
      ana_out.converter_power_bit}, 3'h7);
    apb(1'b1, `ASC_OFF_PWR, 32'h0);
    apb(1'b0, `ASC_OFF_PWR, 0);
    chk(q, 0);
    apb(1'b1, 8'h20, 0);
    chk(q, 1);
    apb(1'b1, `ASC_OFF_PWR, 32'hE0);
  endtask
  task automatic t_run(input logic sim, input logic [3:0] acq, cnt, ch, input int src);
    int t0, n;
    logic [3:0] ca;
    ca = sim ? {1'b0, ch[2:0]} : ch;
    apb(1'b1, `ASC_OFF_STAT, 32'h7);
    apb(1'b1, `ASC_OFF_MASK, {30'h0, sim, !sim});
    apb(1'b1, `ASC_OFF_CHSEL, {28'h0, ch});
    apb(1'b1, `ASC_OFF_CTL, {16'h0, cnt, acq, 3'h0, sim, 1'b0, 3'b001 << src});
    apb(1'b0, `ASC_OFF_CTL, 0);
    chk(q, {16'h0, cnt, acq, 3'h0, sim, 1'b0, 3'b001 << src});
    rise_q.delete();
    fall_q.delete();
    t_irq = -1;
    t0 = cyc + 1;
    trig(src);
    for (n = 0; n < 400 && fall_q.size() <= cnt; n++) @(posedge pclk);
    hang(n);
    repeat (`ASC_LAT_B + `ASC_FLAG_DLY + 2) @(posedge pclk);
    ext_pin <= 1'b0;
    chk(fall_q.size(), cnt + 1);
    chk(fall_q[0] - rise_q[0], acq + 1);
    chk(t_irq - fall_q[0], sim ? 7 : 6);
    if (src < 2) chk(rise_q[0] - t0, `ASC_TRIG_TO_SH + 1 + src);
    for (n = 1; n <= cnt; n++) chk(fall_q[n] - fall_q[n-1], (sim ? 3 : 2) + acq);
    chk(ana_out.chan_a, ca);
    chk(ana_out.chan_b, sim ? {1'b1, ch[2:0]} : ch);
    chk(ana_out.simultaneous, sim);
    apb(1'b0, `ASC_OFF_RES_A, 0);
    chk(q, {8'hC3, ca});
    if (sim) apb(1'b0, `ASC_OFF_RES_B, 0);
    if (sim) chk(q, {8'h3C, 1'b1, ch[2:0]});
    apb(1'b0, `ASC_OFF_STAT, 0);
    chk(q, {30'h0, sim, 1'b1});
    apb(1'b1, `ASC_OFF_STAT, 32'h3);
    @(posedge pclk);
    chk(irq, 0);
  endtask
  task automatic t_drop();
    apb(1'b1, `ASC_OFF_MASK, 32'h4);
    apb(1'b1, `ASC_OFF_CTL, 32'h0F01);
    trig(0);
    trig(3);
    repeat (2) @(posedge pclk);
    chk(irq, 1);
    apb(1'b1, `ASC_OFF_STAT, 32'h7);
    repeat (30) @(posedge pclk);
    apb(1'b1, `ASC_OFF_STAT, 32'h7);
    @(posedge pclk);
    chk(irq, 0);
    apb(1'b1, `ASC_OFF_PWR, 32'h0);
    fall_q.delete();
    trig(0);
    repeat (30) @(posedge pclk);
    chk(fall_q.size(), 0);
    apb(1'b0, `ASC_OFF_STAT, 0);
    chk(q, 4);
  endtask
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, ext_pin} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ev_trig = 2'b00;
    {fails, n_compared, t_irq} = {32'd0, 32'd0, -32'sd1};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `ASC_OFF_STAT, 0);
    chk({q[2:0], irq}, 0);
    t_power();
    t_run(1'b0, 4'h0, 4'h1, 4'h5, 0);
    t_run(1'b0, 4'hF, 4'h2, 4'hA, 1);
    t_run(1'b1, 4'h2, 4'h1, 4'h3, 0);
    t_run(1'b1, 4'h0, 4'h0, 4'h6, 2);
    t_drop();
    finish_test();
  end
endmodule // tb

// File: core/asc_ctrl.sv
// converter sequencer: power bits, triggers, sample/hold timing, results, interrupt
//
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "asc_map.svh"

module asc_ctrl (
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // start sources
  input wire logic [1:0] event_manager_triggers,
  input wire logic external_start_conversion,
  // analog converter core
  output asc_pkg::asc_ana_out_s ana_out,
  input wire asc_pkg::asc_ana_in_s ana_in,
  // interrupt
  output logic irq
);

  asc_pkg::asc_state_s q;
  asc_pkg::asc_state_s d;

  logic acc;
  logic wr_acc;
  logic setup;
  logic hit;
  logic sw_pulse;
  logic ext_rise;
  logic trig_any;
  logic pwr_ok;
  logic go;
  logic drop;
  logic fall_now;
  logic [2:0] st_clr;
  logic [2:0] st_set;

  assign acc = psel & penable;
  assign wr_acc = acc & pwrite;
  assign setup = psel & ~penable;
  assign hit = (paddr == `ASC_OFF_PWR) | (paddr == `ASC_OFF_CTL) |
               (paddr == `ASC_OFF_CHSEL) | (paddr == `ASC_OFF_SWTRIG) |
               (paddr == `ASC_OFF_STAT) | (paddr == `ASC_OFF_MASK) |
               (paddr == `ASC_OFF_RES_A) | (paddr == `ASC_OFF_RES_B);

  // zero wait states: read data is registered in the setup cycle
  assign pready = 1'b1;
  assign pslverr = acc & ~hit;
  assign prdata = q.prdata;

  // start sources, each gated by its own enable
  assign sw_pulse = wr_acc & (paddr == `ASC_OFF_SWTRIG) & pwdata[0];
  // a pin edge counts only once the second and third stages agree
  assign ext_rise = (q.ext_s2 == q.ext_s3) & q.ext_s3 & ~q.ext_lvl;
  assign trig_any = ((|event_manager_triggers) & q.trig_en[`ASC_CTL_EN_EV]) |
                    (sw_pulse & q.trig_en[`ASC_CTL_EN_SW]) |
                    (ext_rise & q.trig_en[`ASC_CTL_EN_EXT]);
  // the settle waits are software's job; hardware only refuses while unpowered
  assign pwr_ok = q.bg & q.refp & q.cv;
  assign go = trig_any & pwr_ok & (q.fsm == asc_pkg::ASC_IDLE);
  // triggers during a run or while powered down are dropped and flagged
  assign drop = trig_any & ~go;
  assign fall_now = (q.fsm == asc_pkg::ASC_SH) & (q.cnt == 4'h0);

  assign st_clr = (wr_acc & (paddr == `ASC_OFF_STAT)) ? pwdata[`ASC_ST_W-1:0] : 3'h0;
  assign st_set = {drop, q.fb[`ASC_FLAG_DLY-1], q.fa[`ASC_FLAG_DLY-1]};

  always_comb begin
    d = q;
    // pin synchroniser
    d.ext_s1 = external_start_conversion;
    d.ext_s2 = q.ext_s1;
    d.ext_s3 = q.ext_s2;
    if (q.ext_s2 == q.ext_s3) begin
      d.ext_lvl = q.ext_s3;
    end

    // register writes take effect at the access edge
    if (wr_acc) begin
      unique case (paddr)
        `ASC_OFF_PWR: begin
          // one write may drop all three together, no order needed
          d.bg = pwdata[`ASC_PWR_BG];
          d.refp = pwdata[`ASC_PWR_REF];
          d.cv = pwdata[`ASC_PWR_CV];
        end
        `ASC_OFF_CTL: begin
          d.trig_en = pwdata[`ASC_CTL_EN_EXT:`ASC_CTL_EN_EV];
          d.sampling_mode_select = pwdata[`ASC_CTL_SAMPLING_MODE_SELECT];
          d.acq_cfg = pwdata[`ASC_CTL_ACQ_MSB:`ASC_CTL_ACQ_LSB];
          d.cnt_cfg = pwdata[`ASC_CTL_CNT_MSB:`ASC_CTL_CNT_LSB];
        end
        `ASC_OFF_CHSEL: d.chsel = pwdata[3:0];
        `ASC_OFF_MASK: d.mask = pwdata[`ASC_ST_W-1:0];
        default: ;
      endcase
    end
    // set wins over a write-one clear in the same cycle
    d.status = (q.status & ~st_clr) | st_set;

    // sequencer: delay, sample/hold pulse, gap, repeat
    unique case (q.fsm)
      asc_pkg::ASC_IDLE: begin
        if (go) begin
          d.fsm = asc_pkg::ASC_DELAY;
          d.cnt = 4'(`ASC_TRIG_TO_SH - 2);
          // mode and width are frozen for the run
          d.mode = q.sampling_mode_select;
          d.acq = q.acq_cfg;
          d.rem = q.cnt_cfg;
        end
      end
      asc_pkg::ASC_DELAY: begin
        if (q.cnt == 4'h0) begin
          d.fsm = asc_pkg::ASC_SH;
          d.sh = 1'b1;
          d.cnt = q.acq;
        end else begin
          d.cnt = q.cnt - 4'h1;
        end
      end
      asc_pkg::ASC_SH: begin
        if (q.cnt == 4'h0) begin
          // falling edge of the pulse is the sampling instant
          d.sh = 1'b0;
          if (q.rem == 4'h0) begin
            d.fsm = asc_pkg::ASC_IDLE;
          end else begin
            d.rem = q.rem - 4'h1;
            d.fsm = asc_pkg::ASC_GAP;
            // one gap clock in sequential, two when a pair is converted
            d.cnt = q.mode ? 4'(`ASC_GAP_SIM - 1) : 4'(`ASC_GAP_SEQ - 1);
          end
        end else begin
          d.cnt = q.cnt - 4'h1;
        end
      end
      asc_pkg::ASC_GAP: begin
        if (q.cnt == 4'h0) begin
          d.fsm = asc_pkg::ASC_SH;
          d.sh = 1'b1;
          d.cnt = q.acq;
        end else begin
          d.cnt = q.cnt - 4'h1;
        end
      end
    endcase

    // result latency pipeline, one bit per sample in flight
    d.pipe = {q.pipe[3:0], fall_now};
    if (q.pipe[`ASC_LAT_A-1]) begin
      d.res_a = ana_in.data_a;
    end
    if (q.pipe[`ASC_LAT_B-1] & q.mode) begin
      d.res_b = ana_in.data_b;
    end
    // flags trail the result update by a couple of clocks
    d.fa = {q.fa[0], q.pipe[`ASC_LAT_A-1]};
    d.fb = {q.fb[0], q.pipe[`ASC_LAT_B-1] & q.mode};

    // read data captured in the setup cycle
    if (setup) begin
      d.prdata = 32'h0;
      unique case (paddr)
        `ASC_OFF_PWR: begin
          d.prdata[`ASC_PWR_BG] = q.bg;
          d.prdata[`ASC_PWR_REF] = q.refp;
          d.prdata[`ASC_PWR_CV] = q.cv;
        end
        `ASC_OFF_CTL: begin
          d.prdata[`ASC_CTL_EN_EXT:`ASC_CTL_EN_EV] = q.trig_en;
          d.prdata[`ASC_CTL_SAMPLING_MODE_SELECT] = q.sampling_mode_select;
          d.prdata[`ASC_CTL_ACQ_MSB:`ASC_CTL_ACQ_LSB] = q.acq_cfg;
          d.prdata[`ASC_CTL_CNT_MSB:`ASC_CTL_CNT_LSB] = q.cnt_cfg;
        end
        `ASC_OFF_CHSEL: d.prdata[3:0] = q.chsel;
        `ASC_OFF_STAT: d.prdata[`ASC_ST_W-1:0] = q.status;
        `ASC_OFF_MASK: d.prdata[`ASC_ST_W-1:0] = q.mask;
        `ASC_OFF_RES_A: d.prdata[11:0] = q.res_a;
        `ASC_OFF_RES_B: d.prdata[11:0] = q.res_b;
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // channel 0..7 form group a, 8..15 group b; a pair shares the low index
  always_comb begin
    ana_out.sh = q.sh;
    ana_out.simultaneous = q.mode;
    ana_out.band_gap_power_bit = q.bg;
    ana_out.reference_power_bit = q.refp;
    ana_out.converter_power_bit = q.cv;
    if (q.mode) begin
      // mixed-index pairs cannot be expressed, so bad selections never reach the core
      ana_out.chan_a = {1'b0, q.chsel[2:0]};
      ana_out.chan_b = {1'b1, q.chsel[2:0]};
    end else begin
      ana_out.chan_a = q.chsel;
      ana_out.chan_b = q.chsel;
    end
  end

  assign irq = |(q.status & q.mask);

  // assertion helpers
  logic [4:0] sh_len_q;
  logic [4:0] per_q;
  logic per_ok_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_len_q <= 5'h00;
      per_q <= 5'h00;
      per_ok_q <= 1'b0;
    end else begin
      sh_len_q <= q.sh ? sh_len_q + 5'h01 : 5'h00;
      per_q <= fall_now ? 5'h00 : ((per_q == 5'h1F) ? per_q : per_q + 5'h01);
      if (fall_now) begin
        per_ok_q <= 1'b1;
      end else if (q.fsm == asc_pkg::ASC_IDLE) begin
        per_ok_q <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_pre_sample;
    !ana_out.sh [*2] ##1 ana_out.sh;
  endsequence

  sequence s_sampled;
    $fell(ana_out.sh);
  endsequence

  a_trig_to_sample: assert property (go |=> s_pre_sample)
    else $error("sample/hold did not rise three clocks after trigger");

  // a trigger that cannot start a run must still leave its mark
  a_no_start_unpowered: assert property (
    q.fsm == asc_pkg::ASC_IDLE && !pwr_ok && trig_any |=>
    q.fsm == asc_pkg::ASC_IDLE && q.status[`ASC_ST_DROP])
    else $error("trigger while unpowered started a run or was not flagged");

  a_busy_drop: assert property (
    q.fsm != asc_pkg::ASC_IDLE && trig_any |=> q.status[`ASC_ST_DROP])
    else $error("trigger during a run was not flagged as dropped");

  // each source on its own must launch a run from a powered idle state
  a_ev_start: assert property (
    q.fsm == asc_pkg::ASC_IDLE && pwr_ok && (|event_manager_triggers) &&
    q.trig_en[`ASC_CTL_EN_EV] |=> q.fsm == asc_pkg::ASC_DELAY)
    else $error("event trigger did not start a run");

  a_sw_start: assert property (
    q.fsm == asc_pkg::ASC_IDLE && pwr_ok && sw_pulse && q.trig_en[`ASC_CTL_EN_SW] |=>
    q.fsm == asc_pkg::ASC_DELAY)
    else $error("software trigger did not start a run");

  a_ext_start: assert property (
    q.fsm == asc_pkg::ASC_IDLE && pwr_ok && ext_rise && q.trig_en[`ASC_CTL_EN_EXT] |=>
    q.fsm == asc_pkg::ASC_DELAY)
    else $error("external start did not start a run");

  a_sh_width: assert property (s_sampled |-> sh_len_q == 5'(q.acq) + 5'h01)
    else $error("sample/hold width differs from acquisition plus one");

  a_sh_max: assert property (ana_out.sh |-> sh_len_q < 5'h10)
    else $error("sample/hold pulse longer than sixteen clocks");

  a_sh_idle: assert property (q.fsm == asc_pkg::ASC_IDLE |-> !ana_out.sh)
    else $error("sample/hold pulse high while the sequencer is idle");

  a_result_a_lat: assert property (s_sampled |-> ##4 q.res_a == $past(ana_in.data_a))
    else $error("first result not loaded four clocks after sampling");

  a_result_a_hold: assert property (!q.pipe[`ASC_LAT_A-1] |=> $stable(q.res_a))
    else $error("first result changed outside its latency slot");

  a_result_b_lat: assert property (
    s_sampled and q.mode |-> ##5 q.res_b == $past(ana_in.data_b))
    else $error("second group result not loaded five clocks after sampling");

  a_seq_no_b: assert property (s_sampled and !q.mode |-> ##5 $stable(q.res_b))
    else $error("second group result changed in sequential mode");

  a_seq_period: assert property (
    fall_now && per_ok_q && !q.mode |-> per_q == 5'(q.acq) + 5'h01)
    else $error("sequential result spacing is not two plus acquisition");

  a_sim_period: assert property (
    fall_now && per_ok_q && q.mode |-> per_q == 5'(q.acq) + 5'h02)
    else $error("simultaneous result spacing is not three plus acquisition");

  a_flag_after_res: assert property (
    s_sampled |-> ##6 (q.status[`ASC_ST_RES_A] && (irq || !q.mask[`ASC_ST_RES_A])))
    else $error("result flag or its interrupt not set two clocks after result update");

  a_pair_select: assert property (
    q.mode |-> ana_out.chan_b == {1'b1, ana_out.chan_a[2:0]} && !ana_out.chan_a[3])
    else $error("simultaneous pair indices do not match");

  a_power_write: assert property (
    wr_acc && paddr == `ASC_OFF_PWR |=> q.cv == $past(pwdata[`ASC_PWR_CV]) &&
    q.bg == $past(pwdata[`ASC_PWR_BG]) && q.refp == $past(pwdata[`ASC_PWR_REF]))
    else $error("power bits not taken from a single write");

  a_mode_frozen: assert property (go |=> q.mode == $past(q.sampling_mode_select))
    else $error("sampling mode not taken from the select bit at start");

endmodule // asc_ctrl

// File: core/asc_map.svh
// register offsets, field positions and timing counts of the converter sequencer
`ifndef ASC_MAP_SVH
`define ASC_MAP_SVH

// register byte offsets on the apb bus
`define ASC_OFF_PWR 8'h00
`define ASC_OFF_CTL 8'h04
`define ASC_OFF_CHSEL 8'h08
`define ASC_OFF_SWTRIG 8'h0C
`define ASC_OFF_STAT 8'h10
`define ASC_OFF_MASK 8'h14
`define ASC_OFF_RES_A 8'h18
`define ASC_OFF_RES_B 8'h1C

// power_control_register bits
`define ASC_PWR_REF 5
`define ASC_PWR_BG 6
`define ASC_PWR_CV 7

// primary_control_register fields
`define ASC_CTL_EN_EV 0
`define ASC_CTL_EN_SW 1
`define ASC_CTL_EN_EXT 2
`define ASC_CTL_SAMPLING_MODE_SELECT 4
`define ASC_CTL_ACQ_LSB 8
`define ASC_CTL_ACQ_MSB 11
`define ASC_CTL_CNT_LSB 12
`define ASC_CTL_CNT_MSB 15

// status and mask bits
`define ASC_ST_RES_A 0
`define ASC_ST_RES_B 1
`define ASC_ST_DROP 2
`define ASC_ST_W 3

// timing
`define ASC_CLK_NS 40
`define ASC_TD_SH_NS 100
`define ASC_TRIG_TO_SH ((`ASC_TD_SH_NS + `ASC_CLK_NS - 1) / `ASC_CLK_NS)
`define ASC_LAT_A 4
`define ASC_LAT_B 5
`define ASC_GAP_SEQ 1
`define ASC_GAP_SIM 2
`define ASC_FLAG_DLY 2

`endif

// File: core/asc_pkg.sv
// types shared by the converter sequencer
package asc_pkg;

  typedef enum logic [1:0] {
    ASC_IDLE,
    ASC_DELAY,
    ASC_SH,
    ASC_GAP
  } asc_fsm_e;

  // control towards the analog converter core
  typedef struct packed {
    logic sh;
    logic simultaneous;
    logic band_gap_power_bit;
    logic reference_power_bit;
    logic converter_power_bit;
    logic [3:0] chan_a;
    logic [3:0] chan_b;
  } asc_ana_out_s;

  // digitised words coming back from the converter pipeline
  typedef struct packed {
    logic [11:0] data_a;
    logic [11:0] data_b;
  } asc_ana_in_s;

  typedef struct packed {
    asc_fsm_e fsm;
    logic [3:0] cnt;
    logic [3:0] rem;
    logic mode;
    logic [3:0] acq;
    logic sh;
    logic [4:0] pipe;
    logic [1:0] fa;
    logic [1:0] fb;
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;
    logic ext_lvl;
    logic bg;
    logic refp;
    logic cv;
    logic [2:0] trig_en;
    logic sampling_mode_select;
    logic [3:0] acq_cfg;
    logic [3:0] cnt_cfg;
    logic [3:0] chsel;
    logic [2:0] status;
    logic [2:0] mask;
    logic [11:0] res_a;
    logic [11:0] res_b;
    logic [31:0] prdata;
  } asc_state_s;

endpackage
